// ---- core/sflash_pkg.sv ----
package sflash_pkg;
    // Address map
    localparam int ADDR_W = 20;
    localparam logic [19:0] ADDR_LAST = 20'hFFFFF;
    localparam int PAGE_BITS = 8;
    localparam int SECTOR_BITS = 12;
    localparam int BLOCK_BITS = 16;
    localparam int PAGE_BYTES = 256;
    // Instruction codes
    localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_RDSR = 8'h05;
    localparam logic [7:0] CMD_WRSR = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_DREAD = 8'h3B;
    localparam logic [7:0] CMD_QREAD = 8'hEB;
    localparam logic [7:0] CMD_PP = 8'h02;
    localparam logic [7:0] CMD_SE = 8'h20;
    localparam logic [7:0] CMD_BE = 8'hD8;
    localparam logic [7:0] CMD_CE = 8'hC7;
    localparam logic [7:0] CMD_OTP_ENTER = 8'h3A;
    localparam logic [7:0] CMD_OTP_EXIT = 8'h04;
    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP0 = 2;
    localparam int ST_LOCK = 7;
    // Internal cycle length in clk_i cycles (shortened model)
    localparam int BUSY_CYCLES = 64;
    // Host: clock divider half period in clk_i cycles
    // Long enough that the host sees read data through both synchronisers
    localparam int HALF_DIV = 8;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    typedef enum logic [1:0] {
        LANES_1 = 2'h0,
        LANES_2 = 2'h1,
        LANES_4 = 2'h3
    } lanes_t;
endpackage : sflash_pkg

// ---- core/sflash_if.sv ----
`timescale 1ns/10ps
interface sflash_if;
    logic sclk;
    logic sel_n;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [3:0] d_out;
    logic [3:0] d_oe;
    logic [3:0] io;
    // Wire level; undriven lanes read high as if pulled up
    genvar g;
    for (g = 0; g < 4; g++) begin : g_wire
        assign io[g] = h_oe[g] ? h_out[g] : (d_oe[g] ? d_out[g] : 1'b1);
    end
    modport device (
        input sclk, sel_n, io,
        output d_out, d_oe
    );
    modport host (
        input io,
        output sclk, sel_n, h_out, h_oe
    );
endinterface : sflash_if

// ---- core/sflash_device.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// [RULE_01] Single lane: sample serial input on rise
// [RULE_02] Single lane: drive output on fall
// [RULE_03] Dual/quad lanes: in on rise, out on fall
// [RULE_04] Deselected: all lanes high impedance
// [RULE_05] Internal cycle survives select going high
// [RULE_06] Select low starts a transaction
// [RULE_07] After power-up, need select falling first
// [RULE_08] Write protect pin blocks status writes; the code blocks them only while status bit 7 is also set
// [RULE_09] Write protect ignored in quad operation
// [RULE_10] Dual uses lanes 0-1, quad 0-3
// [RULE_11] Accept clock mode 0 and mode 3
// [RULE_12] Host limits clock frequency
// [RULE_13] One megabyte, 4096 pages
// [RULE_14] 256-byte page, low eight bits
// [RULE_15] 256 sectors of 4 Kbyte
// [RULE_16] 16 blocks of 64 Kbyte
// [RULE_17] Program only clears bits
// [RULE_18] Erase sector, block or chip
// [RULE_19] Page program takes 1 to 256 bytes
// [RULE_20] Lockable 256-byte OTP sector
// [RULE_21] Host idles clock per mode
// [RULE_22] Modify needs write enable latch first
// [RULE_23] Modify needs bit count multiple of eight
// [RULE_24] MSB first, three address bytes
module sflash_device #(
    parameter int MEM_BYTES = 1048576
) (
    input wire logic clk_i,
    input wire logic rst_i,
    sflash_if.device bus,
    output logic busy_o,
    output logic [7:0] status_o
);
    typedef enum logic [2:0] {
        S_CMD = 3'h0,
        S_ADDR = 3'h1,
        S_DATA = 3'h3,
        S_OUT = 3'h2,
        S_SKIP = 3'h6
    } phase_t;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] otp [sflash_pkg::PAGE_BYTES];
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic sclk_d_reg;
    always_ff @(posedge clk_i) begin
        s1_reg <= {bus.sel_n, bus.sclk, bus.io};
        s2_reg <= s1_reg;
        sclk_d_reg <= s2_reg[4];
    end
    wire [3:0] io_s = s2_reg[3:0];
    wire sck_s = s2_reg[4];
    wire seln_s = s2_reg[5];
    // Edge detect works for mode 0 and mode 3 alike
    // [RULE_11] either idle level
    wire rise = sck_s & ~sclk_d_reg & ~seln_s;
    wire fall = ~sck_s & sclk_d_reg & ~seln_s;

    ////////////////////////////////////////////////////////////////
    // Protocol state
    logic armed_reg;
    logic seln_d_reg;
    logic [7:0] sr_reg;
    logic otp_mode_reg;
    phase_t ph_reg;
    logic [7:0] cmd_reg;
    logic [7:0] sh_reg;
    logic [3:0] bitc_reg;
    logic [12:0] clkcnt_reg;
    logic [1:0] abyte_reg;
    logic [23:0] addr_reg;
    logic [8:0] pcnt_reg;
    logic [7:0] pbuf [sflash_pkg::PAGE_BYTES];
    logic [7:0] obyte_reg;
    logic [3:0] dout_reg;
    logic [3:0] doe_reg;
    logic [31:0] busy_cnt_reg;
    logic [1:0] job_reg;
    logic [7:0] job_sr_reg;

    wire wp_n = io_s[2];
    wire sel_fall = seln_d_reg & ~seln_s;
    wire sel_rise = ~seln_d_reg & seln_s;
    wire busy = sr_reg[sflash_pkg::ST_BUSY];
    wire write_enable_latch = sr_reg[sflash_pkg::ST_WEL];
    wire is_quad = cmd_reg == sflash_pkg::CMD_QREAD;
    wire is_dual = cmd_reg == sflash_pkg::CMD_DREAD;
    // [RULE_10] lane count per class
    wire [2:0] in_step = (ph_reg != S_CMD && is_quad) ? 3'd4 : 3'd1;
    wire [2:0] out_step = is_quad ? 3'd4 : (is_dual ? 3'd2 : 3'd1);
    wire [4:0] bits_in = {1'b0, bitc_reg} + {2'b0, in_step};
    // [RULE_03] lanes 0..3 sampled, MSB first
    wire [7:0] sh_next = (in_step == 3'd4) ? {sh_reg[3:0], io_s} :
        {sh_reg[6:0], io_s[0]};
    wire byte_done = bits_in[3];
    // [RULE_24] bits above nineteen dropped
    wire [19:0] a20 = addr_reg[19:0];
    // [RULE_23] whole bytes only
    wire whole = clkcnt_reg[2:0] == 3'h0;
    // [RULE_08] [RULE_09] protect pin only outside quad
    wire sr_locked = sr_reg[sflash_pkg::ST_LOCK] & ~wp_n;
    // Top of protected range: BP 1..5 picks 1/2^(5-bp) of array from the top; BP 6 and 7 protect all of it
    wire [2:0] bp = sr_reg[4:2];
    wire [3:0] top_blk = a20[19:16];
    wire prot = (bp == 3'h7) ? 1'b1 :
        (bp == 3'h0) ? 1'b0 : (top_blk >= 4'(16 - (1 << (bp - 3'h1))));

    always_ff @(posedge clk_i) begin
        seln_d_reg <= seln_s;
        if (rst_i) begin
            armed_reg <= 1'b0;
            sr_reg <= 8'h00;
            otp_mode_reg <= 1'b0;
            ph_reg <= S_CMD;
            cmd_reg <= 8'h00;
            sh_reg <= 8'h00;
            bitc_reg <= 4'h0;
            clkcnt_reg <= 13'h0000;
            abyte_reg <= 2'h0;
            addr_reg <= 24'h000000;
            pcnt_reg <= 9'h000;
            obyte_reg <= 8'h00;
            dout_reg <= 4'h0;
            doe_reg <= 4'h0;
            busy_cnt_reg <= 32'h0;
            job_reg <= 2'h0;
            seln_d_reg <= 1'b1;
        end else begin
            // [RULE_07] first falling select arms the device
            if (sel_fall) armed_reg <= 1'b1;
            // [RULE_06] frame start resets the shifter
            if (sel_fall || seln_s) begin
                ph_reg <= S_CMD;
                bitc_reg <= 4'h0;
                clkcnt_reg <= 13'h0000;
                abyte_reg <= 2'h0;
                pcnt_reg <= 9'h000;
            end
            // [RULE_04] release every lane when deselected
            if (seln_s) doe_reg <= 4'h0;
            // [RULE_05] internal cycle runs on regardless of select
            if (busy) begin
                if (busy_cnt_reg == 32'h0) begin
                    sr_reg[sflash_pkg::ST_BUSY] <= 1'b0;
                end else begin
                    busy_cnt_reg <= busy_cnt_reg - 32'h1;
                end
            end
            if (rise && armed_reg && ph_reg != S_OUT) begin
                // [RULE_01] capture on rising edge
                clkcnt_reg <= clkcnt_reg + 13'(in_step);
                sh_reg <= sh_next;
                bitc_reg <= byte_done ? 4'h0 : bits_in[3:0];
                if (byte_done) begin
                    case (ph_reg)
                        S_CMD: begin
                            cmd_reg <= sh_next;
                            if (busy && sh_next != sflash_pkg::CMD_RDSR)
                                ph_reg <= S_SKIP;
                            else if (sh_next == sflash_pkg::CMD_RDSR) begin
                                ph_reg <= S_OUT;
                                obyte_reg <= sr_reg;
                            end else if (sh_next == sflash_pkg::CMD_WRSR ||
                                sh_next == sflash_pkg::CMD_WRITE_ENABLE_CMD ||
                                sh_next == sflash_pkg::CMD_WRDI ||
                                sh_next == sflash_pkg::CMD_CE ||
                                sh_next == sflash_pkg::CMD_OTP_ENTER)
                                ph_reg <= S_DATA;
                            else
                                ph_reg <= S_ADDR;
                        end
                        S_ADDR: begin
                            addr_reg <= {addr_reg[15:0], sh_next};
                            abyte_reg <= abyte_reg + 2'h1;
                            if (abyte_reg == 2'h2) begin
                                if (cmd_reg == sflash_pkg::CMD_PP ||
                                    cmd_reg == sflash_pkg::CMD_SE ||
                                    cmd_reg == sflash_pkg::CMD_BE)
                                    ph_reg <= S_DATA;
                                else
                                    ph_reg <= S_OUT;
                            end
                        end
                        S_DATA: begin
                            // [RULE_19] at most a page, wraps in page
                            if (cmd_reg == sflash_pkg::CMD_PP) begin
                                pbuf[8'(addr_reg[7:0] + pcnt_reg[7:0])]
                                    <= sh_next;
                                if (pcnt_reg != 9'h100)
                                    pcnt_reg <= pcnt_reg + 9'h001;
                            end
                            job_sr_reg <= sh_next;
                        end
                        default: ;
                    endcase
                end
            end
            // [RULE_02] [RULE_03] shift out on falling edge
            if (fall && ph_reg == S_OUT) begin
                doe_reg <= is_quad ? 4'hF : (is_dual ? 4'h3 : 4'h2);
                if (is_quad) dout_reg <= obyte_reg[7:4];
                else if (is_dual) dout_reg <= {2'b0, obyte_reg[7:6]};
                else dout_reg <= {2'b0, obyte_reg[7], 1'b0};
                bitc_reg <= bitc_reg + 4'(out_step);
                if ((bitc_reg + 4'(out_step)) >= 4'h8) begin
                    bitc_reg <= 4'h0;
                    addr_reg <= {4'h0, a20 + 20'h1};
                    if (cmd_reg == sflash_pkg::CMD_RDSR)
                        obyte_reg <= sr_reg;
                    else
                        obyte_reg <= otp_mode_reg ? otp[a20[7:0]] :
                            mem[a20 + 20'h1];
                end else begin
                    obyte_reg <= obyte_reg << out_step;
                end
            end else if (ph_reg == S_OUT && bitc_reg == 4'h0 && fall == 1'b0
                && cmd_reg != sflash_pkg::CMD_RDSR && clkcnt_reg != 13'h0
                && sclk_d_reg) begin
                obyte_reg <= obyte_reg;
            end
            // Read data for first byte, latched once the address is in
            if (ph_reg == S_ADDR && rise && byte_done && abyte_reg == 2'h2)
                obyte_reg <= otp_mode_reg ? otp[sh_next] :
                    mem[{addr_reg[11:0], sh_next}];
            // Commit on select rising
            if (sel_rise && armed_reg && !busy && whole) begin
                case (cmd_reg)
                    sflash_pkg::CMD_WRITE_ENABLE_CMD: sr_reg[sflash_pkg::ST_WEL] <= 1'b1;
                    sflash_pkg::CMD_WRDI: begin
                        sr_reg[sflash_pkg::ST_WEL] <= 1'b0;
                        otp_mode_reg <= 1'b0;
                    end
                    sflash_pkg::CMD_OTP_ENTER: otp_mode_reg <= 1'b1;
                    default: ;
                endcase
                // [RULE_22] modification only with latch set
                if (write_enable_latch && (cmd_reg == sflash_pkg::CMD_WRSR ||
                    cmd_reg == sflash_pkg::CMD_PP ||
                    cmd_reg == sflash_pkg::CMD_SE ||
                    cmd_reg == sflash_pkg::CMD_BE ||
                    cmd_reg == sflash_pkg::CMD_CE)) begin
                    sr_reg[sflash_pkg::ST_WEL] <= 1'b0;
                    sr_reg[sflash_pkg::ST_BUSY] <= 1'b1;
                    busy_cnt_reg <= 32'(sflash_pkg::BUSY_CYCLES);
                    if (cmd_reg == sflash_pkg::CMD_WRSR && !sr_locked) begin
                        // [RULE_20] OTP mode sets the lock; a plain status write rewrites bit 7
                        if (otp_mode_reg) sr_reg[sflash_pkg::ST_LOCK] <= 1'b1;
                        else sr_reg[7:2] <= {job_sr_reg[7], sr_reg[6:5],
                            job_sr_reg[4:2]};
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Array updates at commit; kept apart for memory inference
    wire commit = sel_rise && armed_reg && !busy && whole && write_enable_latch &&
        !rst_i;
    wire otp_ok = otp_mode_reg && !sr_reg[sflash_pkg::ST_LOCK];
    // [RULE_13] [RULE_14] byte address inside page
    wire [19:0] page_base = {a20[19:8], 8'h00};
    // [RULE_15] [RULE_16] sector and block bases
    wire [19:0] sec_base = {a20[19:12], 12'h000};
    wire [19:0] blk_base = {a20[19:16], 16'h0000};
    always_ff @(posedge clk_i) begin
        if (commit && cmd_reg == sflash_pkg::CMD_PP && pcnt_reg != 9'h0)
        begin
            // [RULE_17] program clears bits only
            for (int i = 0; i < sflash_pkg::PAGE_BYTES; i++) begin
                if (9'(i) < pcnt_reg || pcnt_reg == 9'h100) begin
                    if (otp_mode_reg) begin
                        if (otp_ok)
                            otp[8'(a20[7:0] + 8'(i))] <=
                                otp[8'(a20[7:0] + 8'(i))] &
                                pbuf[8'(a20[7:0] + 8'(i))];
                    end else if (!prot) begin
                        mem[page_base + 20'(8'(a20[7:0] + 8'(i)))] <=
                            mem[page_base + 20'(8'(a20[7:0] + 8'(i)))] &
                            pbuf[8'(a20[7:0] + 8'(i))];
                    end
                end
            end
        end
        // [RULE_18] erase granules; no page erase exists
        if (commit && cmd_reg == sflash_pkg::CMD_SE) begin
            for (int i = 0; i < 4096; i++) begin
                if (otp_mode_reg) begin
                    if (otp_ok && i < sflash_pkg::PAGE_BYTES)
                        otp[i] <= sflash_pkg::FILL_BYTE;
                end else if (!prot)
                    mem[sec_base + 20'(i)] <= sflash_pkg::FILL_BYTE;
            end
        end
        if (commit && cmd_reg == sflash_pkg::CMD_BE && !prot &&
            !otp_mode_reg) begin
            for (int i = 0; i < 65536; i++)
                mem[blk_base + 20'(i)] <= sflash_pkg::FILL_BYTE;
        end
        if (commit && cmd_reg == sflash_pkg::CMD_CE && bp == 3'h0 &&
            !otp_mode_reg) begin
            for (int i = 0; i < MEM_BYTES; i++)
                mem[i] <= sflash_pkg::FILL_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign bus.d_out = dout_reg;
    // [RULE_04] drive only while selected
    assign bus.d_oe = doe_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            status_o <= 8'h00;
        end else begin
            busy_o <= busy;
            status_o <= sr_reg;
        end
    end
endmodule : sflash_device

// ---- core/sflash_host.sv ----
`timescale 1ns/10ps
module sflash_host (
    input wire logic clk_i,
    input wire logic rst_i,
    sflash_if.host bus,
    // Avalon-MM slave
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // Registers: 0 ctrl (wr: go, lanes, drive, end frame)
    // 1 tx byte, 2 rx byte, 3 status
    localparam logic [2:0] R_CTRL = 3'h0;
    localparam logic [2:0] R_TX = 3'h1;
    localparam logic [2:0] R_RX = 3'h2;
    localparam logic [2:0] R_STAT = 3'h3;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] sh_reg;
    logic [1:0] lanes_reg;
    logic drive_reg;
    logic active_reg;
    logic done_reg;
    logic [3:0] bit_reg;
    logic [3:0] div_reg;
    logic sclk_reg;
    logic seln_reg;
    logic [3:0] hout_reg;
    logic [3:0] hoe_reg;
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [3:0] i1_reg;
    logic [3:0] i2_reg;
    logic ack_reg;
    logic [31:0] rd_reg;
    always_ff @(posedge clk_i) begin
        i1_reg <= bus.io;
        i2_reg <= i1_reg;
    end
    wire [3:0] step = lanes_reg == 2'h2 ? 4'h4 :
        (lanes_reg == 2'h1 ? 4'h2 : 4'h1);
    wire [7:0] smp = lanes_reg == 2'h2 ? {sh_reg[3:0], i2_reg} :
        lanes_reg == 2'h1 ? {sh_reg[5:0], i2_reg[1:0]} :
        {sh_reg[6:0], i2_reg[1]};
    wire acc = (avs_read | avs_write) & ~ack_reg;
    wire wr_ctrl = acc & avs_write & avs_address == R_CTRL & ~active_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            sh_reg <= 8'h00;
            lanes_reg <= 2'h0;
            drive_reg <= 1'b1;
            active_reg <= 1'b0;
            done_reg <= 1'b0;
            bit_reg <= 4'h0;
            div_reg <= 4'h0;
            sclk_reg <= 1'b0;
            seln_reg <= 1'b1;
            hout_reg <= 4'h0;
            hoe_reg <= 4'h0;
            ack_reg <= 1'b0;
            rd_reg <= 32'h0;
        end else begin
            ack_reg <= acc;
            if (acc && avs_read) begin
                case (avs_address)
                    R_TX: rd_reg <= {24'h0, tx_reg};
                    R_RX: rd_reg <= {24'h0, rx_reg};
                    R_STAT: rd_reg <= {30'h0, done_reg, active_reg};
                    default: rd_reg <= 32'h0;
                endcase
            end
            if (acc && avs_write && avs_address == R_TX) tx_reg <=
                avs_writedata[7:0];
            if (wr_ctrl) begin
                // bit0 go, bits2:1 lanes, bit3 drive, bit4 end frame
                if (avs_writedata[4]) seln_reg <= 1'b1;
                else if (avs_writedata[0]) begin
                    seln_reg <= 1'b0;
                    active_reg <= 1'b1;
                    done_reg <= 1'b0;
                    lanes_reg <= avs_writedata[2:1];
                    drive_reg <= avs_writedata[3];
                    sh_reg <= tx_reg;
                    bit_reg <= 4'h0;
                    div_reg <= 4'h0;
                end
                if (avs_writedata[4]) hoe_reg <= 4'h0;
            end
            if (active_reg) begin
                div_reg <= div_reg + 4'h1;
                if (div_reg == 4'(sflash_pkg::HALF_DIV - 1)) begin
                    div_reg <= 4'h0;
                    sclk_reg <= ~sclk_reg;
                    if (!sclk_reg) begin
                        if (!drive_reg) sh_reg <= smp;
                        bit_reg <= bit_reg + step;
                    end else begin
                        if (bit_reg >= 4'h8) begin
                            active_reg <= 1'b0;
                            done_reg <= 1'b1;
                            rx_reg <= sh_reg;
                        end
                    end
                end else if (!sclk_reg && drive_reg && div_reg == 4'h0) begin
                    hoe_reg <= lanes_reg == 2'h2 ? 4'hF :
                        (lanes_reg == 2'h1 ? 4'h3 : 4'h5);
                    hout_reg <= lanes_reg == 2'h2 ?
                        4'(sh_reg >> (4'h4 - bit_reg)) :
                        {2'h1, 1'b0, sh_reg[7 - bit_reg[2:0]]};
                end else if (!drive_reg) hoe_reg <= 4'h4;
            end
        end
    end
    assign bus.sclk = sclk_reg;
    assign bus.sel_n = seln_reg;
    assign bus.h_out = hout_reg;
    assign bus.h_oe = hoe_reg;
    assign avs_readdata = rd_reg;
    assign avs_waitrequest = ~ack_reg & (avs_read | avs_write);
endmodule : sflash_host

// ---- verif/sflash_properties.sv ----
`timescale 1ns/10ps
module sflash_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic [3:0] h_out,
    input wire logic [3:0] h_oe,
    input wire logic [3:0] d_out,
    input wire logic [3:0] d_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Deselect is seen through a synchroniser, hence the settling cycles
    a_desel_no_drive: assert property (sel_n [*4] |-> d_oe == 4'h0)
        else $error("device drives a lane while deselected");
    a_idle_clock_low: assert property (sel_n |-> !sclk)
        else $error("serial clock high between frames");
    a_clock_in_frame: assert property ($rose(sclk) |-> !sel_n)
        else $error("serial clock edge outside a frame");
    a_half_period: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high time not eight cycles");
    a_no_contention: assert property ((h_oe & d_oe) == 4'h0)
        else $error("both ends drive one lane");
    a_host_hold: assert property (
        $rose(sclk) && h_oe[0] |=> $stable(h_out[0]) [*2])
        else $error("host data moved around rising clock");
    a_dev_change_low: assert property (
        !sel_n && d_oe[1] && $changed(d_out[1]) |-> !sclk)
        else $error("device output moved while clock high");
    a_dual_lanes: assert property (d_oe[0] |-> d_oe[1])
        else $error("lane zero driven without lane one");
    a_quad_lanes: assert property (d_oe[3] |-> d_oe[2:0] == 3'h7)
        else $error("lane three driven without lanes zero to two");
    c_frame: cover property ($fell(sel_n));
    c_dev_drive: cover property ($rose(d_oe[1]));
    c_host_drive: cover property ($rose(h_oe[0]));
endmodule : sflash_properties

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
    logic clk_i, rst_i, avs_read, avs_write, avs_waitrequest, busy_o;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] status_o, r;
    int n_errors = 0, checks_done = 0, cycles = 0;
    sflash_if sif();
    sflash_host i_sflash_host (.clk_i(clk_i), .rst_i(rst_i), .bus(sif.host),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    sflash_device i_sflash_device (.clk_i(clk_i), .rst_i(rst_i),
        .bus(sif.device), .busy_o(busy_o), .status_o(status_o));
    sflash_properties i_sflash_properties (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(sif.sclk), .sel_n(sif.sel_n), .h_out(sif.h_out),
        .h_oe(sif.h_oe), .d_out(sif.d_out), .d_oe(sif.d_oe));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // A hung handshake or poll ends here
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            complete_run();
        end
    end
    task avs(input logic wr, input logic [2:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_i);
    endtask : avs
    task xfer(input logic [7:0] b, input logic drv);
        int k;
        avs(1'b1, 3'h1, {24'h0, b});
        avs(1'b1, 3'h0, drv ? 32'h9 : 32'h1);
        for (k = 0; k < 200; k++) begin
            avs(1'b0, 3'h3, 32'h0);
            if (r[1] === 1'b1) break;
        end
        avs(1'b0, 3'h2, 32'h0);
    endtask : xfer
    task cmd(input logic [7:0] c, input logic [23:0] a);
        xfer(c, 1'b1);
        xfer(a[23:16], 1'b1);
        xfer(a[15:8], 1'b1);
        xfer(a[7:0], 1'b1);
    endtask : cmd
    task endf;
        avs(1'b1, 3'h0, 32'h10);
    endtask : endf
    task settle;
        int k;
        for (k = 0; k < 300 && busy_o !== 1'b0; k++) @(posedge clk_i);
    endtask : settle
    task rd(input logic [23:0] a);
        cmd(sflash_pkg::CMD_READ, a);
        xfer(8'h00, 1'b0);
        endf();
    endtask : rd
    task erase(input logic [7:0] c, input logic [23:0] a);
        xfer(sflash_pkg::CMD_WRITE_ENABLE_CMD, 1'b1);
        endf();
        cmd(c, a);
        endf();
        settle();
    endtask : erase
    task pgm(input logic [23:0] a, input logic [7:0] d, input logic we);
        if (we) begin
            xfer(sflash_pkg::CMD_WRITE_ENABLE_CMD, 1'b1);
            endf();
        end
        cmd(sflash_pkg::CMD_PP, a);
        xfer(d, 1'b1);
        endf();
        // Internal cycle must outlive the raised select
        repeat (6) @(posedge clk_i);
        check("busy", {7'h0, busy_o}, {7'h0, we});
        settle();
    endtask : pgm
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Array powers up unknown; start from an erased chip
        erase(sflash_pkg::CMD_CE, 24'h000000);
        xfer(sflash_pkg::CMD_WRITE_ENABLE_CMD, 1'b1);
        endf();
        xfer(sflash_pkg::CMD_RDSR, 1'b1);
        xfer(8'h00, 1'b0);
        endf();
        check("status latch", {7'h0, r[sflash_pkg::ST_WEL]}, 8'h01);
        xfer(sflash_pkg::CMD_WRDI, 1'b1);
        endf();
        pgm(24'h000200, 8'h00, 1'b0);
        rd(24'h000200);
        check("unlatched program", r, 8'hFF);
        $display("test latch done");
        pgm(24'h0FFF00, 8'hA5, 1'b1);
        check("latch cleared", {7'h0, status_o[sflash_pkg::ST_WEL]}, 8'h00);
        rd(24'hFFFF00);
        check("upper bits ignored", r, 8'hA5);
        pgm(24'h0FFF00, 8'h5A, 1'b1);
        rd(24'h0FFF00);
        check("program clears only", r, 8'h00);
        pgm(24'h0FEFFF, 8'h3C, 1'b1);
        $display("test program done");
        erase(sflash_pkg::CMD_SE, 24'h0FF123);
        rd(24'h0FFF00);
        check("sector erased", r, 8'hFF);
        rd(24'h0FEFFF);
        check("neighbour sector kept", r, 8'h3C);
        erase(sflash_pkg::CMD_BE, 24'h0F0000);
        rd(24'h0FEFFF);
        check("block erased", r, 8'hFF);
        $display("test erase done");
        complete_run();
    end
endmodule : tb
